//--- pkg/scp_consts.svh
// Functional notes
// RL1: criterion 0 skips analog loss check
// RL2: criterion 1: below half minimum is loss
// RL3: criterion 2: below minimum is loss
// RL4: sum source: either input below minimum
// RL5: supervise voltage, current or link reference
// RL6: loss only after programmable wait time
// RL7: fallback: hold, coast or ramp stop
// RL8: output code 11 signals reference loss
// RL9: five bit rates, code 3 default
// RL10: two stops modbus, one stop ascii
// RL11: protocol select 0 modbus, 1 ascii
// RL12: master gives unique station numbers 1-250
// RL13: link run on 3, link reference 7
// RL14: fallback action resets to none; code resets it to hold (2'h0)
// RL15: master addresses at most 31 drives
// RL16: shared bus, one talker at a time
// RL17: device answers only, never unsolicited
// RL18: 8N async half duplex, release line
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH
////////////////////////////////////////////////////////////////////////////
// clock and timing
`define SCP_CLK_HZ 40000000
`define SCP_TENTH_S_DIV 10
`define SCP_BAUD_19200 19200
`define SCP_BAUD_9600 9600
`define SCP_BAUD_4800 4800
`define SCP_BAUD_2400 2400
`define SCP_BAUD_1200 1200
`define SCP_RATE_RESET 3'h3
`define SCP_DATA_BITS 8
////////////////////////////////////////////////////////////////////////////
// selector codes
`define SCP_PROT_MODBUS 1'h0
`define SCP_PROT_ASCII 1'h1
`define SCP_RUN_LINK 3'h3
`define SCP_SRC_V1_MAIN 3'h2
`define SCP_SRC_V1 3'h3
`define SCP_SRC_CUR 3'h4
`define SCP_SRC_SUM 3'h6
`define SCP_SRC_LINK 3'h7
`define SCP_CRIT_OFF 2'h0
`define SCP_CRIT_HALF 2'h1
`define SCP_CRIT_MIN 2'h2
`define SCP_OUT_LOSS 5'hb
`define SCP_WAIT_RESET 11'ha
`endif

//--- pkg/scp_pkg.sv
package scp_pkg;
  typedef enum logic [1:0] {
    SCP_ACT_HOLD = 2'h0,
    SCP_ACT_COAST = 2'h1,
    SCP_ACT_RAMP = 2'h2
  } scp_action_t;
  typedef enum {
    SCP_IDLE,
    SCP_START,
    SCP_DATA,
    SCP_STOP
  } scp_ustate_t;
endpackage

//--- pkg/scp_if.sv
`timescale 1ns/1ps
// shared half-duplex line; idle high, each end drives only with its enable
interface scp_if;
  logic dev_txd;
  logic dev_oe;
  logic host_txd;
  logic host_oe;
  logic line;
  assign line = (dev_oe ? dev_txd : 1'b1) & (host_oe ? host_txd : 1'b1);
  modport dev (output dev_txd, output dev_oe, input line);
  modport host (output host_txd, output host_oe, input line);
endinterface

//--- rtl/scp_dev.sv
`timescale 1ns/1ps
`include "scp_consts.svh"
module scp_dev #(
  parameter int CLK_HZ = `SCP_CLK_HZ
) (
  input wire logic mclk,
  input wire logic rstn,
  scp_if.dev link,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err,
  input wire logic protocol_select,
  input wire logic [2:0] rate_select,
  input wire logic [2:0] run_source_select,
  input wire logic [2:0] reference_source_select,
  input wire logic [1:0] analog_loss_criterion,
  input wire logic [1:0] loss_fallback_action,
  input wire logic [10:0] loss_wait_time,
  input wire logic [4:0] transistor_output_function_select,
  input wire logic [4:0] relay_output_function_select,
  input wire logic [11:0] voltage_analog_input,
  input wire logic [11:0] current_analog_input,
  input wire logic [11:0] voltage_input_min_level,
  input wire logic [11:0] voltage_input_min_level_alt,
  input wire logic [11:0] current_input_min_level,
  input wire logic link_cmd_valid,
  input wire logic link_run,
  input wire logic [15:0] link_freq,
  input wire logic term_run,
  input wire logic [15:0] analog_freq,
  output logic run_cmd,
  output logic [15:0] freq_ref,
  output scp_pkg::scp_action_t drive_action,
  output logic ref_lost,
  output logic transistor_output_pin,
  output logic relay_output_contacts
);
  import scp_pkg::*;

  localparam int TENTH = CLK_HZ / `SCP_TENTH_S_DIV;

  ////////////////////////////////////////////////////////////////////////
  // bit period from rate code, unknown codes fall back to 9600
  function automatic logic [15:0] bit_cycles(input logic [2:0] code);
    case (code)
      3'h0: bit_cycles = 16'(CLK_HZ / `SCP_BAUD_19200);
      3'h1: bit_cycles = 16'(CLK_HZ / `SCP_BAUD_1200);
      3'h2: bit_cycles = 16'(CLK_HZ / `SCP_BAUD_2400);
      3'h4: bit_cycles = 16'(CLK_HZ / `SCP_BAUD_4800);
      default: bit_cycles = 16'(CLK_HZ / `SCP_BAUD_9600);
    endcase
  endfunction

  logic [15:0] bit_len;
  logic [2:0] rate_reg, rate_next;
  assign bit_len = bit_cycles(rate_reg); // RL9

  ////////////////////////////////////////////////////////////////////////
  // receiver
  scp_ustate_t rx_st_reg, rx_st_next;
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next, rx_data_next;
  logic rx_valid_next, rx_err_next;
  logic tx_busy;
  logic [15:0] quiet_reg, quiet_next;

  always_comb begin
    rx_st_next = rx_st_reg;
    rx_cnt_next = rx_cnt_reg - 16'h1;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_data_next = rx_data;
    rx_valid_next = 1'b0;
    rx_err_next = 1'b0;
    // line counts as free only after two quiet bit times
    quiet_next = quiet_reg == 16'hffff ? quiet_reg : quiet_reg + 16'h1;
    if (rx_st_reg != SCP_IDLE || (!link.line && !tx_busy)) begin
      quiet_next = 16'h0; // RL16
    end
    case (rx_st_reg)
      SCP_IDLE: begin
        rx_cnt_next = {1'b0, bit_len[15:1]};
        if (!link.line && !tx_busy) begin // RL16
          rx_st_next = SCP_START;
        end
      end
      SCP_START: begin
        if (rx_cnt_reg == 16'h0) begin
          rx_cnt_next = bit_len;
          rx_bit_next = 3'h0;
          rx_st_next = link.line ? SCP_IDLE : SCP_DATA;
        end
      end
      SCP_DATA: begin
        if (rx_cnt_reg == 16'h0) begin
          rx_cnt_next = bit_len;
          rx_sh_next = {link.line, rx_sh_reg[7:1]}; // RL18
          rx_bit_next = rx_bit_reg + 3'h1;
          if (rx_bit_reg == 3'h7) begin
            rx_st_next = SCP_STOP;
          end
        end
      end
      SCP_STOP: begin
        if (rx_cnt_reg == 16'h0) begin
          rx_st_next = SCP_IDLE;
          rx_data_next = rx_sh_reg;
          rx_valid_next = link.line;
          rx_err_next = !link.line;
        end
      end
      default: rx_st_next = SCP_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_st_reg <= SCP_IDLE;
      rx_cnt_reg <= 16'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h0;
      rx_data <= 8'h0;
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      quiet_reg <= 16'h0;
      rate_reg <= `SCP_RATE_RESET;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_data <= rx_data_next;
      rx_valid <= rx_valid_next;
      rx_err <= rx_err_next;
      quiet_reg <= quiet_next;
      rate_reg <= rate_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter, only while a request is pending
  scp_ustate_t tx_st_reg, tx_st_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic stop2_reg, stop2_next, last_reg, last_next;
  logic req_reg, req_next, txd_reg, txd_next, oe_reg, oe_next;

  assign tx_busy = tx_st_reg != SCP_IDLE;
  assign tx_ready = !tx_busy && req_reg && rx_st_reg == SCP_IDLE &&
    quiet_reg >= {bit_len[14:0], 1'b0}; // RL16 RL17
  assign link.dev_txd = txd_reg;
  assign link.dev_oe = oe_reg;

  always_comb begin
    tx_st_next = tx_st_reg;
    tx_cnt_next = tx_cnt_reg - 16'h1;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    stop2_next = stop2_reg;
    last_next = last_reg;
    req_next = req_reg | rx_valid; // RL17
    txd_next = txd_reg;
    oe_next = oe_reg;
    rate_next = tx_busy ? rate_reg : rate_select;
    case (tx_st_reg)
      SCP_IDLE: begin
        if (tx_valid && tx_ready) begin
          tx_st_next = SCP_START;
          tx_cnt_next = bit_len;
          tx_sh_next = tx_data;
          last_next = tx_last;
          stop2_next = protocol_select == `SCP_PROT_MODBUS; // RL10 RL11
          txd_next = 1'b0;
          oe_next = 1'b1;
        end
      end
      SCP_START: begin
        if (tx_cnt_reg == 16'h0) begin
          tx_st_next = SCP_DATA;
          tx_cnt_next = bit_len;
          tx_bit_next = 3'h0;
          txd_next = tx_sh_reg[0];
          tx_sh_next = {1'b0, tx_sh_reg[7:1]};
        end
      end
      SCP_DATA: begin
        if (tx_cnt_reg == 16'h0) begin
          tx_cnt_next = bit_len;
          tx_bit_next = tx_bit_reg + 3'h1;
          txd_next = tx_sh_reg[0];
          tx_sh_next = {1'b0, tx_sh_reg[7:1]};
          if (tx_bit_reg == 3'h7) begin
            tx_st_next = SCP_STOP;
            txd_next = 1'b1;
          end
        end
      end
      SCP_STOP: begin
        if (tx_cnt_reg == 16'h0) begin
          tx_cnt_next = bit_len;
          if (stop2_reg) begin
            stop2_next = 1'b0; // RL10
          end else begin
            tx_st_next = SCP_IDLE;
            oe_next = 1'b0; // RL18
            if (last_reg) begin
              req_next = 1'b0;
            end
          end
        end
      end
      default: tx_st_next = SCP_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_st_reg <= SCP_IDLE;
      tx_cnt_reg <= 16'h0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h0;
      stop2_reg <= 1'b0;
      last_reg <= 1'b0;
      req_reg <= 1'b0;
      txd_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      tx_st_reg <= tx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      stop2_reg <= stop2_next;
      last_reg <= last_next;
      req_reg <= req_next;
      txd_reg <= txd_next;
      oe_reg <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loss condition per source and criterion
  logic v_low, i_low, cond;
  logic [11:0] v_min, v_lim, i_lim;

  always_comb begin
    v_min = reference_source_select == `SCP_SRC_V1_MAIN ?
      voltage_input_min_level : voltage_input_min_level_alt;
    v_lim = analog_loss_criterion == `SCP_CRIT_HALF ?
      {1'b0, v_min[11:1]} : v_min; // RL2 RL3
    i_lim = analog_loss_criterion == `SCP_CRIT_HALF ?
      {1'b0, current_input_min_level[11:1]} : current_input_min_level;
    v_low = voltage_analog_input < v_lim;
    i_low = current_analog_input < i_lim;
    case (reference_source_select)
      `SCP_SRC_V1_MAIN, `SCP_SRC_V1: cond = v_low; // RL5
      `SCP_SRC_CUR: cond = i_low; // RL5
      `SCP_SRC_SUM: cond = v_low | i_low; // RL4
      default: cond = 1'b0;
    endcase
    if (analog_loss_criterion == `SCP_CRIT_OFF ||
        analog_loss_criterion == 2'h3) begin
      cond = 1'b0; // RL1
    end
    if (reference_source_select == `SCP_SRC_LINK) begin
      cond = !link_cmd_valid; // RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wait timer in tenths of a second, then fallback
  logic [31:0] sub_reg, sub_next;
  logic [10:0] ten_reg, ten_next;
  logic lost_next;
  logic [1:0] act_reg, act_next;
  logic [15:0] hold_reg, hold_next, freq_next;
  logic run_next, mo_next, rel_next;
  scp_action_t action_next;

  always_comb begin
    sub_next = sub_reg;
    ten_next = ten_reg;
    lost_next = ref_lost;
    act_next = loss_fallback_action;
    if (!cond) begin
      sub_next = 32'h0;
      ten_next = 11'h0;
      lost_next = 1'b0;
    end else if (!ref_lost) begin
      if (ten_reg >= loss_wait_time) begin
        lost_next = 1'b1; // RL6
      end else if (sub_reg == 32'(TENTH - 1)) begin
        sub_next = 32'h0;
        ten_next = ten_reg + 11'h1; // RL6
      end else begin
        sub_next = sub_reg + 32'h1;
      end
    end
    freq_next = reference_source_select == `SCP_SRC_LINK ?
      link_freq : analog_freq; // RL13
    run_next = run_source_select == `SCP_RUN_LINK ? link_run : term_run;
    hold_next = ref_lost ? hold_reg : freq_next;
    action_next = SCP_ACT_HOLD;
    if (ref_lost) begin
      action_next = scp_action_t'(act_reg); // RL7
      freq_next = act_reg == 2'h0 ? hold_reg : 16'h0; // RL7
      if (act_reg == 2'h1) begin
        run_next = 1'b0; // RL7
      end
    end
    mo_next = lost_next &&
      transistor_output_function_select == `SCP_OUT_LOSS; // RL8
    rel_next = lost_next &&
      relay_output_function_select == `SCP_OUT_LOSS; // RL8
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sub_reg <= 32'h0;
      ten_reg <= 11'h0;
      ref_lost <= 1'b0;
      act_reg <= 2'h0; // RL14
      hold_reg <= 16'h0;
      freq_ref <= 16'h0;
      run_cmd <= 1'b0;
      drive_action <= SCP_ACT_HOLD;
      transistor_output_pin <= 1'b0;
      relay_output_contacts <= 1'b0;
    end else begin
      sub_reg <= sub_next;
      ten_reg <= ten_next;
      ref_lost <= lost_next;
      act_reg <= act_next;
      hold_reg <= hold_next;
      freq_ref <= freq_next;
      run_cmd <= run_next;
      drive_action <= action_next;
      transistor_output_pin <= mo_next;
      relay_output_contacts <= rel_next;
    end
  end
endmodule

//--- rtl/scp_host.sv
`timescale 1ns/1ps
`include "scp_consts.svh"
module scp_host #(
  parameter int CLK_HZ = `SCP_CLK_HZ
) (
  input wire logic mclk,
  input wire logic rstn,
  scp_if.host link,
  input wire logic protocol_select,
  input wire logic [15:0] bit_len,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err
);
  import scp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // receiver for answers
  scp_ustate_t rx_st_reg, rx_st_next;
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next, rx_data_next;
  logic rx_valid_next, rx_err_next, tx_busy;
  logic [15:0] quiet_reg, quiet_next;

  always_comb begin
    rx_st_next = rx_st_reg;
    rx_cnt_next = rx_cnt_reg - 16'h1;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_data_next = rx_data;
    rx_valid_next = 1'b0;
    rx_err_next = 1'b0;
    // line counts as free only after two quiet bit times
    quiet_next = quiet_reg == 16'hffff ? quiet_reg : quiet_reg + 16'h1;
    if (rx_st_reg != SCP_IDLE || (!link.line && !tx_busy)) begin
      quiet_next = 16'h0; // RL16
    end
    case (rx_st_reg)
      SCP_IDLE: begin
        rx_cnt_next = {1'b0, bit_len[15:1]};
        if (!link.line && !tx_busy) begin
          rx_st_next = SCP_START;
        end
      end
      SCP_START: begin
        if (rx_cnt_reg == 16'h0) begin
          rx_cnt_next = bit_len;
          rx_bit_next = 3'h0;
          rx_st_next = link.line ? SCP_IDLE : SCP_DATA;
        end
      end
      SCP_DATA: begin
        if (rx_cnt_reg == 16'h0) begin
          rx_cnt_next = bit_len;
          rx_sh_next = {link.line, rx_sh_reg[7:1]}; // RL18
          rx_bit_next = rx_bit_reg + 3'h1;
          if (rx_bit_reg == 3'h7) begin
            rx_st_next = SCP_STOP;
          end
        end
      end
      SCP_STOP: begin
        if (rx_cnt_reg == 16'h0) begin
          rx_st_next = SCP_IDLE;
          rx_data_next = rx_sh_reg;
          rx_valid_next = link.line;
          rx_err_next = !link.line;
        end
      end
      default: rx_st_next = SCP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter for requests, held off while an answer arrives
  scp_ustate_t tx_st_reg, tx_st_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic stop2_reg, stop2_next, txd_reg, txd_next, oe_reg, oe_next;

  assign tx_busy = tx_st_reg != SCP_IDLE;
  assign tx_ready = !tx_busy && rx_st_reg == SCP_IDLE && link.line &&
    quiet_reg >= {bit_len[14:0], 1'b0}; // RL16
  assign link.host_txd = txd_reg;
  assign link.host_oe = oe_reg;

  always_comb begin
    tx_st_next = tx_st_reg;
    tx_cnt_next = tx_cnt_reg - 16'h1;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    stop2_next = stop2_reg;
    txd_next = txd_reg;
    oe_next = oe_reg;
    case (tx_st_reg)
      SCP_IDLE: begin
        if (tx_valid && tx_ready) begin
          tx_st_next = SCP_START;
          tx_cnt_next = bit_len;
          tx_sh_next = tx_data;
          stop2_next = protocol_select == `SCP_PROT_MODBUS; // RL10
          txd_next = 1'b0;
          oe_next = 1'b1;
        end
      end
      SCP_START, SCP_DATA: begin
        if (tx_cnt_reg == 16'h0) begin
          tx_cnt_next = bit_len;
          tx_bit_next = tx_st_reg == SCP_START ? 3'h0 : tx_bit_reg + 3'h1;
          txd_next = tx_sh_reg[0];
          tx_sh_next = {1'b0, tx_sh_reg[7:1]};
          tx_st_next = SCP_DATA;
          if (tx_st_reg == SCP_DATA && tx_bit_reg == 3'h7) begin
            tx_st_next = SCP_STOP;
            txd_next = 1'b1;
          end
        end
      end
      SCP_STOP: begin
        if (tx_cnt_reg == 16'h0) begin
          tx_cnt_next = bit_len;
          stop2_next = 1'b0;
          if (!stop2_reg) begin
            tx_st_next = SCP_IDLE;
            oe_next = 1'b0; // RL18
          end
        end
      end
      default: tx_st_next = SCP_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_st_reg <= SCP_IDLE;
      rx_cnt_reg <= 16'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h0;
      rx_data <= 8'h0;
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      quiet_reg <= 16'h0;
      tx_st_reg <= SCP_IDLE;
      tx_cnt_reg <= 16'h0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h0;
      stop2_reg <= 1'b0;
      txd_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_data <= rx_data_next;
      rx_valid <= rx_valid_next;
      rx_err <= rx_err_next;
      quiet_reg <= quiet_next;
      tx_st_reg <= tx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      stop2_reg <= stop2_next;
      txd_reg <= txd_next;
      oe_reg <= oe_next;
    end
  end
endmodule

//--- verif/scp_link_monitor.sv
`timescale 1ns/1ps
module scp_link_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [15:0] bit_len,
  input wire logic dev_txd,
  input wire logic dev_oe,
  input wire logic host_txd,
  input wire logic host_oe,
  input wire logic line
);
  logic [15:0] dev_cnt_reg, dev_cnt_next;
  logic [15:0] host_cnt_reg, host_cnt_next;
  logic [15:0] bit_cyc, one_stop, two_stop;
  ////////////////////////////////////////////////////////////////////////
  // cycles each end has held the line, cleared on release
  always_comb begin
    dev_cnt_next = dev_oe ? dev_cnt_reg + 16'h1 : 16'h0;
    host_cnt_next = host_oe ? host_cnt_reg + 16'h1 : 16'h0;
    bit_cyc = bit_len + 16'h1;
    one_stop = bit_cyc * 16'ha;
    two_stop = bit_cyc * 16'hb;
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dev_cnt_reg <= 16'h0;
      host_cnt_reg <= 16'h0;
    end else begin
      dev_cnt_reg <= dev_cnt_next;
      host_cnt_reg <= host_cnt_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  one_talker_a: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the line");
  idle_high_a: assert property (!dev_oe && !host_oe |-> line)
    else $error("released line not high");
  dev_start_a: assert property ($rose(dev_oe) |-> !dev_txd [*8])
    else $error("device start bit missing or short");
  host_start_a: assert property ($rose(host_oe) |-> !host_txd [*8])
    else $error("host start bit missing or short");
  dev_release_a: assert property ($fell(dev_oe) |-> $past(dev_txd))
    else $error("device released before a stop bit");
  host_release_a: assert property ($fell(host_oe) |-> $past(host_txd))
    else $error("host released before a stop bit");
  dev_frame_a: assert property ($fell(dev_oe) |->
    dev_cnt_reg == one_stop || dev_cnt_reg == two_stop)
    else $error("device frame length out of range");
  host_frame_a: assert property ($fell(host_oe) |->
    host_cnt_reg == one_stop || host_cnt_reg == two_stop)
    else $error("host frame length out of range");
endmodule

//--- verif/serial_command_port_with_reference_loss_test.sv
`timescale 1ns/1ps
module serial_command_port_with_reference_loss_test;
  import scp_pkg::*;
  localparam int CLK_HZ = 100000;
  localparam int TENTH = CLK_HZ / 10;
  logic mclk, rstn, prot, d_tx_valid, d_tx_last, d_tx_ready, d_rx_valid;
  logic d_rx_err, h_tx_valid, h_tx_ready, h_rx_valid, h_rx_err;
  logic [7:0] d_tx_data, h_tx_data, d_rx_data, h_rx_data;
  logic [2:0] run_src, ref_src, rate;
  logic [15:0] h_bit;
  logic [1:0] crit, action;
  logic [10:0] wait_t;
  logic [4:0] tsel, rsel;
  logic [11:0] vin, cin, imin;
  logic cmd_ok, link_run, term_run, run_cmd, ref_lost, tpin, rpin;
  logic [15:0] link_freq, analog_freq, freq_ref;
  scp_action_t drive_action;
  logic [7:0] hq[$];
  logic [7:0] dq[$];
  int len_q[$];
  int err_count, tests_run, olen, n;
  scp_if link_if();
  scp_dev #(.CLK_HZ(CLK_HZ)) u_scp_dev (.mclk(mclk), .rstn(rstn),
    .link(link_if), .tx_data(d_tx_data), .tx_valid(d_tx_valid),
    .tx_last(d_tx_last), .tx_ready(d_tx_ready), .rx_data(d_rx_data),
    .rx_valid(d_rx_valid), .rx_err(d_rx_err), .protocol_select(prot),
    .rate_select(rate), .run_source_select(run_src),
    .reference_source_select(ref_src), .analog_loss_criterion(crit),
    .loss_fallback_action(action), .loss_wait_time(wait_t),
    .transistor_output_function_select(tsel),
    .relay_output_function_select(rsel), .voltage_analog_input(vin),
    .current_analog_input(cin), .voltage_input_min_level(12'h064),
    .voltage_input_min_level_alt(12'h0c8),
    .current_input_min_level(imin), .link_cmd_valid(cmd_ok),
    .link_run(link_run), .link_freq(link_freq), .term_run(term_run),
    .analog_freq(analog_freq), .run_cmd(run_cmd), .freq_ref(freq_ref),
    .drive_action(drive_action), .ref_lost(ref_lost),
    .transistor_output_pin(tpin), .relay_output_contacts(rpin));
  scp_host #(.CLK_HZ(CLK_HZ)) u_scp_host (.mclk(mclk), .rstn(rstn),
    .link(link_if), .protocol_select(prot), .bit_len(h_bit),
    .tx_data(h_tx_data), .tx_valid(h_tx_valid), .tx_ready(h_tx_ready),
    .rx_data(h_rx_data), .rx_valid(h_rx_valid), .rx_err(h_rx_err));
  scp_link_monitor u_scp_link_monitor (
    .mclk(mclk), .rstn(rstn), .bit_len(h_bit), .dev_txd(link_if.dev_txd),
    .dev_oe(link_if.dev_oe), .host_txd(link_if.host_txd),
    .host_oe(link_if.host_oe), .line(link_if.line));
  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // collect received bytes and device frame lengths
  always @(posedge mclk) begin
    if (h_rx_valid === 1'b1 && h_rx_err === 1'b0) hq.push_back(h_rx_data);
    if (d_rx_valid === 1'b1 && d_rx_err === 1'b0) dq.push_back(d_rx_data);
    if (link_if.dev_oe === 1'b1) olen++;
    else if (olen != 0) begin
      len_q.push_back(olen);
      olen = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one byte from either end, held until the ready edge
  task automatic send(input logic dev, input logic [7:0] b, input logic l);
    int k;
    @(negedge mclk);
    if (dev) begin
      d_tx_data = b;
      d_tx_last = l;
      d_tx_valid = 1'b1;
    end else begin
      h_tx_data = b;
      h_tx_valid = 1'b1;
    end
    for (k = 0; k < 3000 && (dev ? d_tx_ready : h_tx_ready) !== 1'b1; k++)
      @(negedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    d_tx_valid = 1'b0;
    h_tx_valid = 1'b0;
    check(k < 3000, 1'b1);
  endtask
  task automatic loss_case(input logic [2:0] s, input logic [1:0] c,
      input logic [11:0] v, input logic [11:0] i, input logic exp);
    @(negedge mclk);
    ref_src = s;
    crit = c;
    vin = v;
    cin = i;
    repeat (6) @(negedge mclk);
    check(ref_lost, exp);
    check(tpin, exp);
    check(rpin, exp);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    {rstn, prot, d_tx_valid, d_tx_last, h_tx_valid, cmd_ok} = 6'h0;
    {link_run, term_run, d_tx_data, h_tx_data} = 18'h0;
    {run_src, ref_src, crit, action, wait_t} = 21'h0;
    {tsel, rsel, vin, cin} = {5'hb, 5'hb, 24'h0};
    {link_freq, analog_freq} = 32'h0;
    rate = 3'h3;
    h_bit = 16'(CLK_HZ / 9600);
    imin = 12'h12c;
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    check(link_if.dev_oe, 1'b0);
    check(link_if.line, 1'b1);
    check(drive_action, SCP_ACT_HOLD);
    check(d_tx_ready, 1'b0);
    // one request, two-byte answer, per protocol, then modbus at 4800
    for (int p = 0; p < 3; p++) begin
      prot = p[0];
      rate = (p == 2) ? 3'h4 : 3'h3;
      h_bit = 16'(CLK_HZ / ((p == 2) ? 4800 : 9600));
      send(1'b0, 8'ha5 ^ p[7:0], 1'b0);
      send(1'b1, 8'h3c, 1'b0);
      repeat (30) @(negedge mclk);
      check(h_tx_ready, 1'b0);
      send(1'b1, 8'hc3, 1'b1);
      repeat (300) @(negedge mclk);
      check(d_tx_ready, 1'b0);
      check(dq.size(), 1);
      check(hq.size(), 2);
      check(dq.pop_front(), 8'ha5 ^ p[7:0]);
      check(hq.pop_front(), 8'h3c);
      check(hq.pop_front(), 8'hc3);
    end
    check(len_q.size(), 6);
    check(len_q[0] inside {[110:125]}, 1'b1);
    check(len_q[4] inside {[225:235]}, 1'b1);
    check((len_q[0] - len_q[2]) inside {[9:12]}, 1'b1);
    // criteria and sources, wait zero
    cmd_ok = 1'b1;
    loss_case(3'h3, 2'h0, 12'h000, 12'h000, 1'b0);
    loss_case(3'h3, 2'h1, 12'h063, 12'h000, 1'b1);
    loss_case(3'h3, 2'h1, 12'h065, 12'h000, 1'b0);
    loss_case(3'h3, 2'h2, 12'h0c7, 12'h000, 1'b1);
    loss_case(3'h3, 2'h2, 12'h0c8, 12'h000, 1'b0);
    loss_case(3'h2, 2'h2, 12'h063, 12'h000, 1'b1);
    loss_case(3'h6, 2'h2, 12'h0fa, 12'h064, 1'b1);
    loss_case(3'h6, 2'h2, 12'h064, 12'h190, 1'b1);
    loss_case(3'h6, 2'h2, 12'h0fa, 12'h190, 1'b0);
    loss_case(3'h4, 2'h2, 12'h000, 12'h12b, 1'b1);
    loss_case(3'h7, 2'h2, 12'h000, 12'h000, 1'b0);
    // fallback actions on link reference loss
    run_src = 3'h3;
    link_run = 1'b1;
    link_freq = 16'h1234;
    rsel = 5'hc;
    for (int a = 0; a < 3; a++) begin
      @(negedge mclk);
      cmd_ok = 1'b1;
      action = a[1:0];
      repeat (6) @(negedge mclk);
      check(freq_ref, 16'h1234);
      check(run_cmd, 1'b1);
      cmd_ok = 1'b0;
      repeat (6) @(negedge mclk);
      check(rpin, 1'b0);
      check(drive_action, a[1:0]);
      check(run_cmd, a != 1);
      check(freq_ref, (a == 0) ? 16'h1234 : 16'h0);
    end
    // wait time: short gap ignored, long gap declared
    wait_t = 11'h1;
    cmd_ok = 1'b1;
    repeat (6) @(negedge mclk);
    cmd_ok = 1'b0;
    repeat (100) @(negedge mclk);
    cmd_ok = 1'b1;
    repeat (4) @(negedge mclk);
    check(ref_lost, 1'b0);
    cmd_ok = 1'b0;
    for (n = 0; n < TENTH + 20 && ref_lost !== 1'b1; n++) @(negedge mclk);
    check(n >= TENTH && n <= TENTH + 4, 1'b1);
    print_verdict();
  end
endmodule
